/* File: core/sscp_pkg.sv */
// Constants shared by the serial command port design files.
package sscp_pkg;
    // ****************************************
    // Frame shape
    // ****************************************
    localparam int unsigned BYTE_BITS     = 8;
    localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;
    localparam logic [2:0]  BIT_CNT_RST   = 3'h0;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    // Sampling on rising clock edges is the mode taken out of reset.
    localparam logic        MODE_RISE_RST = 1'b1;
    localparam logic        HOLD_RST      = 1'b1;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned SYS_CLK_NS     = 40;
    localparam int unsigned SCK_MIN_HALF_NS = 100;
    // Least time, so round up to whole system clocks.
    localparam int unsigned SCK_MIN_HALF_CYC =
        (SCK_MIN_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int unsigned SYNC_STAGES    = 2;

    // ****************************************
    // Port state
    // ****************************************
    typedef enum logic [1:0] {
        SSCP_IDLE   = 2'b00,
        SSCP_ACTIVE = 2'b01
    } sscp_state_t;
endpackage

/* File: core/sscp_sync.sv */
// Two-flop synchroniser for one pin level.
`timescale 1ns/10ps
`default_nettype none
module sscp_sync
    import sscp_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic sys_clk,   // System clock.
    input  wire logic reset,     // Synchronous reset, active high.
    input  wire logic pin_in,    // Asynchronous pin level.
    output logic      level_out  // Level after two flops.
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
    end

    // The flops follow the pin through reset, so the level is already true
    // at release. A forced reset value would step to the pin level after
    // release and look like a pin edge or a select fall.
    always_ff @(posedge sys_clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign level_out = sync_q;
endmodule
`default_nettype wire

/* File: core/sscp_port.sv */
// Clock-synchronous serial command port, device end.
// Notes on behaviour
// - Command bits arrive on the serial input MSB first, one per serial clock, after chip select falls.
// - A command byte is complete and latched on the eighth counted serial clock.
// - While chip select is low, status bits are shifted out in step with the serial clock, except zeros in the first byte with select held low from reset.
// - At each chip select fall the serial clock level is caught and picks the sampling and driving edges.
// - A high serial clock at the fall means sample on rising edges and drive on falling edges.
// - A low serial clock at the fall means sample on falling edges and drive on rising edges.
// - With chip select held low from reset, sampling is on rising edges and driving on falling edges.
// - Every serial clock pulse is counted, so the host must avoid glitches and resynchronise with chip select.
// - While chip select is high the port waits in idle, clearing count and partial byte; the edge mode is kept.
// - The serial output is floated for as long as chip select is high.
`timescale 1ns/10ps
`default_nettype none
module sscp_port
    import sscp_pkg::*;
(
    input  wire logic       sys_clk,       // System clock, 25 MHz.
    input  wire logic       reset,         // Synchronous reset, active high.
    input  wire logic       chip_select_n, // Chip select pin, active low.
    input  wire logic       sck,           // Serial clock pin from host.
    input  wire logic       si,            // Serial data in pin.
    output logic            so_out,        // Serial data out value.
    output logic            so_oe,         // Serial out enable, high drives.
    input  wire logic [7:0] status_byte,   // Status to send, same clock.
    output logic [7:0]      cmd_byte,      // Last complete command byte.
    output logic            cmd_valid,     // One-cycle pulse per byte.
    output logic            sample_rise    // Current sampling edge mode.
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic cs_s;
    logic sck_s;
    logic si_s;

    sscp_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (chip_select_n),
        .level_out (cs_s)
    );
    sscp_sync #(.RST_VAL(1'b0)) u_sync_sck (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (sck),
        .level_out (sck_s)
    );
    sscp_sync #(.RST_VAL(1'b0)) u_sync_si (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (si),
        .level_out (si_s)
    );

    // ****************************************
    // Edge detection and select tracking
    // ****************************************
    logic        sck_prev_q;
    logic        sck_prev_d;
    sscp_state_t state_q;
    sscp_state_t state_d;
    logic        mode_q;
    logic        mode_d;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic        sample;
    logic        drive;

    always_comb begin
        sck_rise   = sck_s & ~sck_prev_q;
        sck_fall   = ~sck_s & sck_prev_q;
        sck_prev_d = sck_s;
        cs_fall    = (state_q == SSCP_IDLE) & ~cs_s;
        mode_d     = mode_q;
        if (cs_fall) begin
            mode_d = sck_s;
        end
        // A glitch on the clock is a real edge here; nothing filters it.
        sample = ~cs_s & (mode_q ? sck_rise : sck_fall);
        drive  = ~cs_s & (mode_q ? sck_fall : sck_rise);
        case (state_q)
            SSCP_IDLE:   state_d = cs_s ? SSCP_IDLE : SSCP_ACTIVE;
            SSCP_ACTIVE: state_d = cs_s ? SSCP_IDLE : SSCP_ACTIVE;
            default:     state_d = SSCP_IDLE;
        endcase
    end

    // Reset starts active so that a select tied low keeps the default mode.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Track the settled clock so no false edge follows reset.
            sck_prev_q <= sck_s;
            state_q    <= SSCP_ACTIVE;
            mode_q     <= MODE_RISE_RST;
        end else begin
            sck_prev_q <= sck_prev_d;
            state_q    <= state_d;
            mode_q     <= mode_d;
        end
    end

    // ****************************************
    // Receive shifter
    // ****************************************
    logic [2:0] bit_cnt_q;
    logic [2:0] bit_cnt_d;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic [7:0] cmd_q;
    logic [7:0] cmd_d;
    logic       cmd_vld_q;
    logic       cmd_vld_d;
    logic       byte_done;

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        rx_d      = rx_q;
        cmd_d     = cmd_q;
        cmd_vld_d = 1'b0;
        byte_done = sample & (bit_cnt_q == LAST_BIT_IDX);
        if (cs_s) begin
            bit_cnt_d = BIT_CNT_RST;
            rx_d      = BYTE_RST;
        end else if (byte_done) begin
            cmd_d     = {rx_q[6:0], si_s};
            cmd_vld_d = 1'b1;
            bit_cnt_d = BIT_CNT_RST;
            rx_d      = BYTE_RST;
        end else if (sample) begin
            rx_d      = {rx_q[6:0], si_s};
            bit_cnt_d = bit_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bit_cnt_q <= BIT_CNT_RST;
            rx_q      <= BYTE_RST;
            cmd_q     <= BYTE_RST;
            cmd_vld_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            rx_q      <= rx_d;
            cmd_q     <= cmd_d;
            cmd_vld_q <= cmd_vld_d;
        end
    end

    // ****************************************
    // Transmit shifter
    // ****************************************
    // The first drive edge of each byte only holds the MSB already loaded,
    // which lets one path serve both edge modes.
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic       hold_q;
    logic       hold_d;
    logic       oe_q;
    logic       oe_d;

    always_comb begin
        tx_d   = tx_q;
        hold_d = hold_q;
        oe_d   = ~cs_s;
        if (cs_s || byte_done) begin
            tx_d   = status_byte;
            hold_d = HOLD_RST;
        end else if (drive) begin
            if (hold_q) begin
                hold_d = 1'b0;
            end else begin
                tx_d = {tx_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_q   <= BYTE_RST;
            hold_q <= HOLD_RST;
            oe_q   <= 1'b0;
        end else begin
            tx_q   <= tx_d;
            hold_q <= hold_d;
            oe_q   <= oe_d;
        end
    end

    assign so_out      = tx_q[7];
    assign so_oe       = oe_q;
    assign cmd_byte    = cmd_q;
    assign cmd_valid   = cmd_vld_q;
    assign sample_rise = mode_q;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_cs_fall;
        (state_q == SSCP_IDLE) && !cs_s;
    endsequence

    sequence s_mid_sample;
        sample && !cs_s && (bit_cnt_q != LAST_BIT_IDX);
    endsequence

    a_msb_shift_in: assert property (
        @(posedge sys_clk) disable iff (reset)
        s_mid_sample |=> (rx_q[0] == $past(si_s))
            && (rx_q[7:1] == $past(rx_q[6:0])))
        else $error("serial input bit not shifted in");

    a_eighth_latch: assert property (
        @(posedge sys_clk) disable iff (reset)
        cmd_valid |-> $past(sample) && ($past(bit_cnt_q) == 3'h7)
            && (cmd_byte[0] == $past(si_s)))
        else $error("command byte latched at wrong count");

    a_tx_shift: assert property (
        @(posedge sys_clk) disable iff (reset)
        drive && !hold_q && !byte_done |=> so_out == $past(tx_q[6]))
        else $error("status bit not shifted out");

    a_mode_capture: assert property (
        @(posedge sys_clk) disable iff (reset)
        s_cs_fall |=> (sample_rise == $past(sck_s)))
        else $error("edge mode not caught at select fall");

    a_rise_mode: assert property (
        @(posedge sys_clk) disable iff (reset)
        sample_rise && !cs_s && sck_s && !sck_prev_q |-> sample && !drive)
        else $error("rising edge not sampling in rise mode");

    a_fall_mode: assert property (
        @(posedge sys_clk) disable iff (reset)
        !sample_rise && !cs_s && !sck_s && sck_prev_q |-> sample && !drive)
        else $error("falling edge not sampling in fall mode");

    a_reset_mode: assert property (
        @(posedge sys_clk)
        reset |=> sample_rise && (state_q == SSCP_ACTIVE))
        else $error("reset did not select rise mode");

    a_idle_clear: assert property (
        @(posedge sys_clk) disable iff (reset)
        cs_s [*2] |-> (bit_cnt_q == 3'h0) && (rx_q == 8'h00))
        else $error("port not cleared while deselected");

    a_idle_float: assert property (
        @(posedge sys_clk) disable iff (reset)
        cs_s |=> !so_oe)
        else $error("serial output driven while deselected");

    a_byte_restart: assert property (
        @(posedge sys_clk) disable iff (reset)
        cmd_valid |-> (bit_cnt_q == 3'h0) && (rx_q == 8'h00) && hold_q)
        else $error("count did not restart after byte");
endmodule
`default_nettype wire

/* File: verif/sscp_host.sv */
// Host-side serial master model driving the command port.
`timescale 1ns/10ps
`default_nettype none
module sscp_host (
    output var logic chip_select_n, // Select, active low.
    output var logic sck,           // Serial clock.
    output var logic si,            // Serial data to device.
    input  wire logic so_line       // Resolved serial data from device.
);
    // ****************************************
    // Frame tasks
    // ****************************************
    // Four system clocks a half period keep data steady through the syncs.
    localparam int HALF = 160;

    // Select starts low, as if tied low, until the first release.
    initial begin
        chip_select_n = 1'b0;
        sck           = 1'b1;
        si            = 1'b0;
    end

    // The idle clock level chosen here picks the device's edge mode.
    task automatic select(input logic idle);
        sck = idle;
        #HALF;
        chip_select_n = 1'b0;
        #200;
    endtask

    // Data moves on the drive edge; output is read just before the next.
    task automatic bit_io(input logic b, output logic r);
        si = b;
        sck = ~sck;
        #HALF;
        sck = ~sck;
        #HALF;
        r = so_line;
    endtask

    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask

    // Raising select is the only resync; the other port is never used.
    task automatic release_sel();
        #HALF;
        chip_select_n = 1'b1;
        si = ~si;
        #200;
    endtask
endmodule
`default_nettype wire

/* File: verif/sync_serial_command_port_tb.sv */
// Self-checking bench for the serial command port.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_command_port_tb;
    logic       sys_clk, reset, so_out, so_oe, cmd_valid, sample_rise;
    logic [7:0] status_byte, cmd_byte, rx;
    wire        chip_select_n, sck, si, so_line;
    int         err_count, n_tests, cyc;
    logic [7:0] got_q[$];

    assign so_line = so_oe ? so_out : 1'bz;

    sscp_port dut (.sys_clk, .reset, .chip_select_n, .sck, .si, .so_out,
        .so_oe, .status_byte, .cmd_byte, .cmd_valid, .sample_rise);
    sscp_host host (.chip_select_n, .sck, .si, .so_line);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // A missed or doubled pulse shows up as a wrong queue length.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) got_q.push_back(cmd_byte);
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic expect_cmd(input logic [7:0] exp);
        check(got_q.size() > 0 ? got_q.pop_front() : 8'hxx, exp);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_held_low();
        host.xfer_byte(8'h96, rx);
        check({7'h0, sample_rise}, 8'h01);
        check(rx, 8'h00);
        host.release_sel();
        expect_cmd(8'h96);
    endtask

    task automatic t_modes();
        logic [7:0] st;
        for (int m = 0; m < 2; m++) begin
            st = m ? 8'h5a : 8'h81;
            @(negedge sys_clk) status_byte = st;
            host.select(m[0]);
            check({7'h0, so_oe}, 8'h01);
            host.xfer_byte(~st, rx);
            check({7'h0, sample_rise}, {7'h0, m[0]});
            check(rx, st);
            host.release_sel();
            expect_cmd(~st);
            check({7'h0, so_oe}, 8'h00);
        end
    endtask

    task automatic t_multi();
        @(negedge sys_clk) status_byte = 8'h24;
        host.select(1'b0);
        host.xfer_byte(8'h01, rx);
        check(rx, 8'h24);
        host.xfer_byte(8'hfe, rx);
        check(rx, 8'h24);
        host.release_sel();
        expect_cmd(8'h01);
        expect_cmd(8'hfe);
    endtask

    task automatic t_abort();
        logic r;
        host.select(1'b1);
        repeat (5) host.bit_io(1'b1, r);
        host.release_sel();
        check({7'h0, so_oe}, 8'h00);
        check(8'(got_q.size()), 8'h00);
        host.select(1'b1);
        host.xfer_byte(8'h42, rx);
        host.release_sel();
        expect_cmd(8'h42);
    endtask

    // No glitch filter, so one stray pulse shifts the byte by a bit.
    task automatic t_glitch();
        logic r;
        host.select(1'b1);
        host.bit_io(1'b1, r);
        host.xfer_byte(8'h00, rx);
        host.release_sel();
        expect_cmd(8'h80);
        check(8'(got_q.size()), 8'h00);
    endtask

    initial begin
        reset       = 1'b1;
        status_byte = 8'h00;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk) reset = 1'b0;
        repeat (3) @(negedge sys_clk);
        t_held_low();
        t_modes();
        t_multi();
        t_abort();
        t_glitch();
        tally_and_finish();
    end
endmodule
`default_nettype wire
